/* File: design/fll_clock_mode_select.sv */
// Function
// (RL1) request field and separate actual-mode status
// (RL2) status follows request only after settle delay
// (RL3) first write with reference zero locks it
// (RL4) self-clocked output ignores reference, compare continues
// (RL5) engaged external: divide by 2R until locked
// (RL6) fixed clock equals bus clock otherwise
// (RL7) engaged external: fixed = ext/2 when ratio, lock
// (RL8) fixed clock off in engaged internal, self-clocked
// (RL9) peripherals avoid fixed clock in those modes
// (RL10) high gain effective only with reference select
// (RL11) high gain bit writable once per reset
// (RL12) output: loop/R, ext/R, internal multiply per N/R
// (RL13) engaged external multiplier uses range prescale
// (RL14) multiply codes decode to 4 through 18
// (RL15) divide codes decode to 1 through 128
// (RL16) comparison cycle 8 internal, 2/128 external
// (RL17) actual mode held short on missing conditions
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module fll_clock_mode_select (
    input wire logic clk,
    input wire logic rst_n,
    input wire fll_clock_pkg::apb_req_t apbReq,
    output fll_clock_pkg::apb_rsp_t apbRsp,
    input wire fll_clock_pkg::clk_pins_t clkPins,
    input wire fll_clock_pkg::loop_flags_t loopFlags,
    output fll_clock_pkg::clk_out_t clkOut
);
    import fll_clock_pkg::*;

    localparam int NSYNC = 7;

    typedef struct packed {
        logic [7:0] ctrl1;
        logic [7:0] ctrl2;
        logic firstWriteDone;
        logic refLocked;
        clk_mode_t mode;
        logic [3:0] settle;
        logic hasLocked;
        logic busPhase;
        logic [NSYNC-1:0] syncA;
        logic [NSYNC-1:0] syncB;
        logic [2:0] prevClk;
        apb_rsp_t rsp;
        clk_out_t out;
    } top_state_t;

    top_state_t s_q, s_d;

    logic genTick, cmpTick, fixedExtTick;
    logic genClear, cmpClear;
    logic [8:0] genDivisor, cmpDivisor;
    logic genSrc, cmpSrc;

    // decoded fields and synchronised inputs
    logic loopEdge, extEdge, intEdge;
    logic extValid, oscStable, lossFlag, lockFlag;
    clk_mode_t modeReq, target;
    logic [4:0] mulN;
    logic [7:0] divR;
    logic [11:0] prescale, ratioLhs, ratioRhs;
    logic ratioOk;
    logic refSel, rangeBit;

    always_comb begin
        extValid = s_q.syncB[3];
        oscStable = s_q.syncB[4];
        lossFlag = s_q.syncB[5];
        lockFlag = s_q.syncB[6];
        loopEdge = s_q.syncB[0] & ~s_q.prevClk[0];
        extEdge = s_q.syncB[1] & ~s_q.prevClk[1];
        intEdge = s_q.syncB[2] & ~s_q.prevClk[2];
        modeReq = clk_mode_t'(s_q.ctrl1[C1_MODE_HI:C1_MODE_LO]);
        refSel = s_q.ctrl1[C1_REF_SEL];
        rangeBit = s_q.ctrl1[C1_RANGE];
        mulN = MUL_BASE + {1'b0, s_q.ctrl2[C2_MUL_HI:C2_MUL_LO], 1'b0}; // [RL14]
        divR = DIV_BASE << s_q.ctrl2[C2_DIV_HI:C2_DIV_LO]; // [RL15]
        prescale = rangeBit ? PRESCALE_HI_RANGE : PRESCALE_LO_RANGE; // [RL13]
        ratioLhs = 12'(prescale * {7'h00, mulN});
        ratioRhs = 12'({4'h0, divR} * MIN_FIXED_RATIO);
        ratioOk = ratioLhs >= ratioRhs; // [RL7]
    end

    // mode the generator may run given the detector flags
    always_comb begin
        target = MODE_SELF_CLOCKED;
        unique case (modeReq)
            MODE_SELF_CLOCKED: begin
                target = MODE_SELF_CLOCKED;
            end
            MODE_ENGAGED_INT: begin
                target = oscStable ? MODE_ENGAGED_INT : MODE_SELF_CLOCKED; // [RL17]
            end
            MODE_BYPASSED_EXT: begin
                target = extValid ? MODE_BYPASSED_EXT : MODE_SELF_CLOCKED; // [RL17]
            end
            MODE_ENGAGED_EXT: begin
                if (!extValid || !oscStable) begin
                    target = MODE_SELF_CLOCKED; // [RL17]
                end else if (lossFlag) begin
                    target = MODE_BYPASSED_EXT; // [RL17]
                end else begin
                    target = MODE_ENGAGED_EXT;
                end
            end
        endcase
    end

    // output divider source and ratio; every mode but bypassed external runs from the loop oscillator
    always_comb begin
        genSrc = loopEdge; // [RL4] [RL12]
        genDivisor = {1'b0, divR};
        if (s_q.mode == MODE_BYPASSED_EXT) begin
            genSrc = extEdge; // [RL12]
        end else if (s_q.mode == MODE_ENGAGED_EXT && !lockFlag && !s_q.hasLocked) begin
            genDivisor = {divR, 1'b0}; // [RL5]
        end
        cmpSrc = 1'b0;
        cmpDivisor = CMP_INT_PERIODS;
        unique case (s_q.mode)
            MODE_SELF_CLOCKED, MODE_ENGAGED_INT: begin
                cmpSrc = intEdge; // [RL4] [RL16]
            end
            MODE_ENGAGED_EXT: begin
                cmpSrc = extEdge;
                cmpDivisor = rangeBit ? CMP_EXT_HI_RANGE : CMP_EXT_LO_RANGE; // [RL16]
            end
            MODE_BYPASSED_EXT: begin
                cmpSrc = 1'b0;
            end
        endcase
    end

    tick_divider #(.W(9)) genDiv (
        .clk(clk),
        .rst_n(rst_n),
        .clear(genClear),
        .srcTick(genSrc),
        .divisor(genDivisor),
        .tick(genTick)
    );

    tick_divider #(.W(9)) cmpDiv (
        .clk(clk),
        .rst_n(rst_n),
        .clear(cmpClear),
        .srcTick(cmpSrc),
        .divisor(cmpDivisor),
        .tick(cmpTick)
    );

    // runs free, so ext/2 is ready the moment ratio and lock allow it
    tick_divider #(.W(9)) fixedDiv (
        .clk(clk),
        .rst_n(rst_n),
        .clear(1'b0),
        .srcTick(extEdge),
        .divisor(FIXED_EXT_DIV),
        .tick(fixedExtTick)
    );

    // writes take effect only on the access edge that pready qualifies
    logic setup, access, wrCtrl1, wrCtrl2;
    logic [7:0] wdata, newCtrl1, newCtrl2, statusRd;
    logic fixedOff;

    always_comb begin
        setup = apbReq.psel & ~apbReq.penable;
        access = apbReq.psel & apbReq.penable & s_q.rsp.pready;
        wdata = apbReq.pwdata[7:0];
        wrCtrl1 = access & apbReq.pwrite & (apbReq.paddr == ADDR_CTRL1);
        wrCtrl2 = access & apbReq.pwrite & (apbReq.paddr == ADDR_CTRL2);
        fixedOff = (s_q.mode == MODE_ENGAGED_INT) || (s_q.mode == MODE_SELF_CLOCKED);
        genClear = wrCtrl2;
        cmpClear = (s_q.mode != s_d.mode);

        newCtrl1 = (s_q.ctrl1 & ~CTRL1_WMASK) | (wdata & CTRL1_WMASK);
        if (s_q.firstWriteDone) begin
            newCtrl1[C1_HIGH_GAIN] = s_q.ctrl1[C1_HIGH_GAIN]; // [RL11]
        end
        if (s_q.refLocked) begin
            newCtrl1[C1_REF_SEL] = 1'b0; // [RL3]
        end
        newCtrl2 = wdata & CTRL2_WMASK;

        // status is built live; reading it never disturbs the mode logic
        statusRd = '0;
        statusRd[ST_MODE_HI:ST_MODE_LO] = s_q.mode; // [RL1]
        statusRd[ST_LOCK] = lockFlag;
        statusRd[ST_OSC_STABLE] = oscStable;
        statusRd[ST_EXT_VALID] = extValid;
        statusRd[ST_CLOCK_LOSS] = lossFlag;
        statusRd[ST_REF_LOCKED] = s_q.refLocked;
        statusRd[ST_FIXED_OFF] = fixedOff; // [RL9]
    end

    always_comb begin
        s_d = s_q;

        // pins cross into clk through two flops before use
        s_d.syncA = {loopFlags, clkPins};
        s_d.syncB = s_q.syncA;
        s_d.prevClk = s_q.syncB[2:0];

        // single-wait-free slave: answer is ready in the first access cycle
        // the whole response stands one cycle, so a stale error never trails pready
        s_d.rsp = '0;
        if (setup) begin
            s_d.rsp.pready = 1'b1;
            s_d.rsp.pslverr = 1'b0;
            s_d.rsp.prdata = '0;
            unique case (apbReq.paddr)
                ADDR_CTRL1: s_d.rsp.prdata = {24'h000000, s_q.ctrl1};
                ADDR_CTRL2: s_d.rsp.prdata = {24'h000000, s_q.ctrl2};
                ADDR_STATUS: s_d.rsp.prdata = {24'h000000, statusRd};
                default: s_d.rsp.pslverr = 1'b1;
            endcase
        end else if (access) begin
            s_d.rsp.pready = 1'b0;
        end

        if (wrCtrl1) begin
            s_d.ctrl1 = newCtrl1;
            s_d.firstWriteDone = 1'b1;
            if (!s_q.firstWriteDone && !wdata[C1_REF_SEL]) begin
                s_d.refLocked = 1'b1; // [RL3]
                s_d.ctrl1[C1_REF_SEL] = 1'b0;
            end
        end
        if (wrCtrl2) begin
            s_d.ctrl2 = newCtrl2;
            // a new multiplier restarts the slow locking phase
            if (newCtrl2[C2_MUL_HI:C2_MUL_LO] != s_q.ctrl2[C2_MUL_HI:C2_MUL_LO]) begin
                s_d.hasLocked = 1'b0; // [RL5]
            end
        end

        // status lags a request write; detector changes still pass after settling
        if (s_q.settle != 4'h0) begin
            s_d.settle = s_q.settle - 4'h1; // [RL2]
        end else if (!wrCtrl1) begin
            s_d.mode = target; // [RL1] [RL17]
        end
        // a request landing mid-settle restarts the full delay instead of shortening it
        if (wrCtrl1 && newCtrl1[C1_MODE_HI:C1_MODE_LO] != s_q.ctrl1[C1_MODE_HI:C1_MODE_LO]) begin
            s_d.settle = SETTLE_CYCLES; // [RL2]
        end

        if (s_d.mode != MODE_ENGAGED_EXT || s_q.mode != MODE_ENGAGED_EXT) begin
            if (s_d.mode != s_q.mode) begin
                s_d.hasLocked = 1'b0; // [RL5]
            end
        end else if (lockFlag && !wrCtrl2) begin
            s_d.hasLocked = 1'b1;
        end

        if (genTick) begin
            s_d.busPhase = ~s_q.busPhase;
        end

        s_d.out.generatorTick = genTick;
        s_d.out.busTick = genTick & s_q.busPhase;
        if (fixedOff) begin
            s_d.out.fixedTick = 1'b0; // [RL8]
        end else if (s_q.mode == MODE_ENGAGED_EXT && ratioOk && lockFlag) begin
            s_d.out.fixedTick = fixedExtTick; // [RL7]
        end else begin
            s_d.out.fixedTick = genTick & s_q.busPhase; // [RL6]
        end
        s_d.out.compareTick = cmpTick; // [RL16]
        // amplifier only runs for a crystal request that was not locked out
        s_d.out.oscAmpEnable = refSel & ~s_q.refLocked & s_q.ctrl1[C1_MODE_HI]; // [RL3]
        s_d.out.highGainEnable = s_q.ctrl1[C1_HIGH_GAIN] & refSel; // [RL10]
        s_d.out.modeActual = s_q.mode; // [RL1]
        // multiplier is reported only where the loop is engaged
        unique case (s_q.mode)
            MODE_ENGAGED_INT: s_d.out.targetMul = 11'(PRESCALE_INTERNAL * {7'h00, mulN}); // [RL12]
            MODE_ENGAGED_EXT: s_d.out.targetMul = 11'(ratioLhs); // [RL13]
            default: s_d.out.targetMul = '0;
        endcase
    end

    // control bytes reset to their package values; ctrl1 is nonzero, ctrl2 is zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.ctrl1 <= CTRL1_RESET;
            s_q.ctrl2 <= CTRL2_RESET;
            s_q.mode <= MODE_SELF_CLOCKED;
        end else begin
            s_q <= s_d;
        end
    end

    assign apbRsp = s_q.rsp;
    assign clkOut = s_q.out;

endmodule

`default_nettype wire

/* File: design/fll_clock_pkg.sv */
package fll_clock_pkg;

    // register byte addresses on the APB window
    localparam logic [7:0] ADDR_CTRL1 = 8'h00;
    localparam logic [7:0] ADDR_CTRL2 = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;

    // first_control_reg field positions
    localparam int C1_HIGH_GAIN = 7;
    localparam int C1_RANGE = 6;
    localparam int C1_REF_SEL = 5;
    localparam int C1_MODE_HI = 4;
    localparam int C1_MODE_LO = 3;
    localparam int C1_OSC_STOP_EN = 2;
    localparam int C1_LOSS_DET_DIS = 1;

    // second control register field positions
    localparam int C2_MUL_HI = 6;
    localparam int C2_MUL_LO = 4;
    localparam int C2_DIV_HI = 2;
    localparam int C2_DIV_LO = 0;

    // status register field positions
    localparam int ST_MODE_HI = 1;
    localparam int ST_MODE_LO = 0;
    localparam int ST_LOCK = 2;
    localparam int ST_OSC_STABLE = 3;
    localparam int ST_EXT_VALID = 4;
    localparam int ST_CLOCK_LOSS = 5;
    localparam int ST_REF_LOCKED = 6;
    localparam int ST_FIXED_OFF = 7;

    localparam logic [7:0] CTRL1_RESET = 8'h20;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] CTRL1_WMASK = 8'hFE;
    localparam logic [7:0] CTRL2_WMASK = 8'h77;

    // bus-cycle delay before the reported mode follows a new request
    localparam logic [3:0] SETTLE_CYCLES = 4'h6;

    // comparison cycle lengths in reference periods
    localparam logic [8:0] CMP_INT_PERIODS = 9'h008;
    localparam logic [8:0] CMP_EXT_LO_RANGE = 9'h002;
    localparam logic [8:0] CMP_EXT_HI_RANGE = 9'h080;

    localparam logic [8:0] FIXED_EXT_DIV = 9'h002;
    localparam logic [11:0] PRESCALE_LO_RANGE = 12'h040;
    localparam logic [11:0] PRESCALE_HI_RANGE = 12'h001;
    localparam logic [11:0] PRESCALE_INTERNAL = 12'h040;
    localparam logic [11:0] MIN_FIXED_RATIO = 12'h004;
    localparam logic [4:0] MUL_BASE = 5'h04;
    localparam logic [7:0] DIV_BASE = 8'h01;

    typedef enum logic [1:0] {
        MODE_SELF_CLOCKED = 2'b00,
        MODE_ENGAGED_INT = 2'b01,
        MODE_BYPASSED_EXT = 2'b10,
        MODE_ENGAGED_EXT = 2'b11
    } clk_mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // raw source clocks arriving on pins
    typedef struct packed {
        logic intRef;
        logic extRef;
        logic loopOsc;
    } clk_pins_t;

    // flags from the lock and loss-of-clock detectors
    typedef struct packed {
        logic lockFlag;
        logic clockLoss;
        logic loopOscStable;
        logic extRefValid;
    } loop_flags_t;

    typedef struct packed {
        logic generatorTick;
        logic busTick;
        logic fixedTick;
        logic compareTick;
        logic oscAmpEnable;
        logic highGainEnable;
        clk_mode_t modeActual;
        logic [10:0] targetMul;
    } clk_out_t;

endpackage

/* File: design/tick_divider.sv */
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
    parameter int W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic srcTick,
    input wire logic [W-1:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [W-1:0] count;
        logic tick;
    } div_state_t;

    div_state_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (clear) begin
            s_d.count = '0;
        end else if (srcTick) begin
            // a divisor of zero behaves as one rather than stalling
            if (s_q.count + W'(1) >= divisor) begin
                s_d.count = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.count = s_q.count + W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

`default_nettype wire

/* File: dv/fll_clock_mode_select_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module fll_clock_mode_select_assertions
    import fll_clock_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire apb_req_t apbReq,
    input wire apb_rsp_t apbRsp,
    input wire clk_out_t clkOut
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic wrC1;
    assign wrC1 = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite
        && apbReq.paddr == ADDR_CTRL1;

    sequence setupS; apbReq.psel && !apbReq.penable; endsequence
    sequence answerS; apbRsp.pready ##1 !apbRsp.pready; endsequence
    // two cycles of a mode, so the registered ticks have caught up with it
    sequence offModeS;
        (clkOut.modeActual inside {MODE_SELF_CLOCKED, MODE_ENGAGED_INT})[*2];
    endsequence
    sequence bypModeS; (clkOut.modeActual == MODE_BYPASSED_EXT)[*2]; endsequence

    chk_apb_answer: assert property (setupS |=> answerS)
        else $error("pready not a pulse after setup");
    chk_err_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
        else $error("pslverr without pready");
    chk_mode_hold: assert property (wrC1 |=> $stable(clkOut.modeActual)[*5])
        else $error("mode moved right after request");
    chk_fixed_off: assert property (offModeS |-> !clkOut.fixedTick)
        else $error("fixed clock ran in off mode");
    chk_fixed_bus: assert property (bypModeS |-> clkOut.fixedTick == clkOut.busTick)
        else $error("fixed clock differs from bus clock");
    chk_no_compare: assert property (bypModeS |-> !clkOut.compareTick)
        else $error("compare tick in bypass");
    chk_mul_self: assert property ((clkOut.modeActual == MODE_SELF_CLOCKED)[*2]
        |-> clkOut.targetMul == 11'h000)
        else $error("multiplier set in self-clocked");
    chk_mul_int: assert property ((clkOut.modeActual == MODE_ENGAGED_INT)[*2]
        |-> clkOut.targetMul[5:0] == 6'h00 && !clkOut.targetMul[6]
        && clkOut.targetMul[10:6] inside {[4:18]})
        else $error("internal multiplier out of range");
    chk_hg_rise: assert property ($rose(clkOut.highGainEnable)
        |-> $past(wrC1) || $past(wrC1, 2) || $past(wrC1, 3))
        else $error("high gain rose without a write");
endmodule

bind fll_clock_mode_select fll_clock_mode_select_assertions fll_clock_mode_select_assertions_i (
    .clk(clk),
    .rst_n(rst_n),
    .apbReq(apbReq),
    .apbRsp(apbRsp),
    .clkOut(clkOut)
);

`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import fll_clock_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_t apbReq = '0;
    apb_rsp_t apbRsp;
    clk_pins_t clkPins = '0;
    loop_flags_t loopFlags = '0;
    clk_out_t clkOut;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int nG = 0, nB = 0, nF = 0, nC = 0;
    int dG, dB, dF, dC;
    logic [3:0] div = 4'h0;
    logic [31:0] rd;
    logic er;

    fll_clock_mode_select fll_clock_mode_select_i (
        .clk(clk),
        .rst_n(rst_n),
        .apbReq(apbReq),
        .apbRsp(apbRsp),
        .clkPins(clkPins),
        .loopFlags(loopFlags),
        .clkOut(clkOut)
    );

    always #2 clk = ~clk;

    // sources are much slower than clk so the 2FF edge detectors never miss one
    always @(posedge clk) begin
        cycles <= cycles + 1;
        div <= div + 4'h1;
        clkPins.loopOsc <= div[1];
        clkPins.extRef <= div[2];
        clkPins.intRef <= div[3];
        nG <= nG + int'(clkOut.generatorTick === 1'b1);
        nB <= nB + int'(clkOut.busTick === 1'b1);
        nF <= nF + int'(clkOut.fixedTick === 1'b1);
        nC <= nC + int'(clkOut.compareTick === 1'b1);
        if (cycles == 30000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    // window edges may cut one tick either way
    task automatic near(input int got, input int exp);
        cmp_count++;
        if (got < exp - 1 || got > exp + 1) begin
            errors++;
            $display("[FAIL] %0t count %0d exp %0d", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        // wait as long as the slave needs; only the bench timeout ends a hang
        do begin
            @(posedge clk);
        end while (apbRsp.pready !== 1'b1);
        rd = apbRsp.prdata;
        er = apbRsp.pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        // one idle edge so the next call never reassigns psel in this time step
        @(posedge clk);
    endtask

    task automatic meas(input int n);
        int g, b, f, c;
        g = nG;
        b = nB;
        f = nF;
        c = nC;
        repeat (n) @(posedge clk);
        dG = nG - g;
        dB = nB - b;
        dF = nF - f;
        dC = nC - c;
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask

    task automatic t_regs();
        apb(1'b0, ADDR_CTRL1, 8'h00);
        check(rd, 32'h20);
        apb(1'b0, ADDR_CTRL2, 8'h00);
        check(rd, 32'h0);
        apb(1'b0, ADDR_STATUS, 8'h00);
        check(rd[1:0], MODE_SELF_CLOCKED);
        apb(1'b0, 8'h0C, 8'h00);
        check(er, 1'b1);
        check(rd, 32'h0);
    endtask

    task automatic t_high_gain();
        apb(1'b1, ADDR_CTRL1, 8'hA0);
        repeat (4) @(posedge clk);
        check(clkOut.highGainEnable, 1'b1);
        apb(1'b1, ADDR_CTRL1, 8'h00);
        repeat (4) @(posedge clk);
        check(clkOut.highGainEnable, 1'b0);
        apb(1'b1, ADDR_CTRL1, 8'h30);
        apb(1'b0, ADDR_CTRL1, 8'h00);
        check(rd[7], 1'b1);
        repeat (4) @(posedge clk);
        check(clkOut.highGainEnable, 1'b1);
        check(clkOut.oscAmpEnable, 1'b1);
    endtask

    task automatic t_lockout();
        apb(1'b1, ADDR_CTRL1, 8'h98);
        apb(1'b1, ADDR_CTRL1, 8'h38);
        apb(1'b0, ADDR_CTRL1, 8'h00);
        check(rd, 32'h98);
        apb(1'b0, ADDR_STATUS, 8'h00);
        check(rd[ST_REF_LOCKED], 1'b1);
        repeat (4) @(posedge clk);
        check(clkOut.oscAmpEnable, 1'b0);
        check(clkOut.highGainEnable, 1'b0);
    endtask

    task automatic t_modes();
        loopFlags <= 4'b1011;
        repeat (8) @(posedge clk);
        apb(1'b1, ADDR_CTRL1, 8'h28);
        apb(1'b0, ADDR_STATUS, 8'h00);
        check(rd[1:0], MODE_SELF_CLOCKED);
        check(rd[ST_FIXED_OFF], 1'b1);
        repeat (12) @(posedge clk);
        check(clkOut.modeActual, MODE_ENGAGED_INT);
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, ADDR_CTRL2, 8'(m << 4));
            repeat (3) @(posedge clk);
            check(clkOut.targetMul, 32'(64 * (4 + 2 * m)));
        end
        meas(320);
        check(dF, 0);
        apb(1'b1, ADDR_CTRL1, 8'h20);
        // slow divide codes get a window of about ten output ticks
        for (int r = 0; r < 8; r++) begin
            apb(1'b1, ADDR_CTRL2, 8'(r));
            repeat (12) @(posedge clk);
            meas(r < 4 ? 320 : 40 << r);
            near(dG, r < 4 ? 80 >> r : 10);
        end
        meas(640);
        near(dC, 5);
        check(dF, 0);
        apb(1'b1, ADDR_CTRL2, 8'h01);
        apb(1'b1, ADDR_CTRL1, 8'h30);
        repeat (12) @(posedge clk);
        check(clkOut.modeActual, MODE_BYPASSED_EXT);
        apb(1'b0, ADDR_STATUS, 8'h00);
        check(rd[ST_FIXED_OFF], 1'b0);
        meas(320);
        near(dG, 20);
        near(dB, 10);
        near(dF, dB);
        apb(1'b1, ADDR_CTRL2, 8'h30);
        apb(1'b1, ADDR_CTRL1, 8'h38);
        repeat (12) @(posedge clk);
        check(clkOut.modeActual, MODE_ENGAGED_EXT);
        check(clkOut.targetMul, 32'd640);
        meas(320);
        near(dC, 20);
        near(dG, 80);
        near(dF, 20);
        apb(1'b1, ADDR_CTRL1, 8'h78);
        repeat (12) @(posedge clk);
        check(clkOut.targetMul, 32'd10);
        apb(1'b1, ADDR_CTRL2, 8'h32);
        repeat (8) @(posedge clk);
        meas(320);
        near(dG, 20);
        near(dF, dB);
        loopFlags.lockFlag <= 1'b0;
        apb(1'b1, ADDR_CTRL2, 8'h40);
        repeat (8) @(posedge clk);
        meas(320);
        near(dG, 40);
        loopFlags.lockFlag <= 1'b1;
        repeat (8) @(posedge clk);
        meas(320);
        near(dG, 80);
        loopFlags.lockFlag <= 1'b0;
        repeat (8) @(posedge clk);
        meas(320);
        near(dG, 80);
        loopFlags.extRefValid <= 1'b0;
        repeat (8) @(posedge clk);
        check(clkOut.modeActual, MODE_SELF_CLOCKED);
        loopFlags <= 4'b1111;
        repeat (8) @(posedge clk);
        check(clkOut.modeActual, MODE_BYPASSED_EXT);
        loopFlags.clockLoss <= 1'b0;
        repeat (8) @(posedge clk);
        check(clkOut.modeActual, MODE_ENGAGED_EXT);
    endtask

    initial begin
        do_reset();
        t_regs();
        t_high_gain();
        do_reset();
        t_lockout();
        do_reset();
        t_modes();
        end_of_test();
    end
endmodule

`default_nettype wire
